/* File: design/link_regs_pkg.sv */
// Shared constants, types and helpers for the link register slice.
// Assumes a single host bus clock domain and 32-bit register words.
package link_regs_pkg;

    // Register byte offsets, decoded from the low address bits only.
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_MASK_SET = 12'h0a8;
    localparam logic [11:0] OFS_MASK_CLEAR = 12'h0ac;
    localparam logic [11:0] OFS_FAIRNESS = 12'h0dc;
    localparam logic [11:0] OFS_LINK_SET = 12'h0e0;
    localparam logic [11:0] OFS_LINK_CLEAR = 12'h0e4;
    localparam logic [11:0] OFS_INT_STATUS = 12'h100;
    localparam logic [11:0] OFS_INT_CLEAR = 12'h104;
    localparam logic [11:0] OFS_INT_ENABLE = 12'h108;

    // Field widths, positions and reset values.
    localparam int MASK_BITS = 4;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [7:0] FAIRNESS_RESET = 8'h00;
    localparam int EXT_SEL_BIT = 22;
    localparam int MASTER_BIT = 21;
    localparam int COUNT_BIT = 20;
    localparam int PHY_BIT = 10;
    localparam int SELF_ID_BIT = 9;
    localparam int INT_BITS = 3;
    localparam int INT_ROLLOVER = 0;
    localparam int INT_MASTER_DROP = 1;
    localparam int INT_FAIR_FULL = 2;
    localparam logic [2:0] INT_RESET = 3'h0;

    // Cycle timer: 3072 periods of the 24.576 MHz tick make one cycle.
    localparam int OFFSET_W = 12;
    localparam logic [11:0] ROLLOVER_TICKS = 12'hc00;

    // Software-alterable link control bits.
    typedef struct packed {
        logic external_rollover_select;
        logic cycle_start_generator_enable;
        logic cycle_counting_enable;
        logic phy_packet_accept;
        logic self_id_accept;
    } link_cfg_s;
    localparam link_cfg_s LINK_RESET = '0;

    // Latched address phase of a bus transfer.
    typedef struct packed {
        logic [11:0] addr;
        logic write;
    } bus_req_s;

    // Bus slave states.
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_read = 2'b10,
        st_read_out = 2'b11
    } bus_state_e;

    // Places the link control bits at their word positions.
    function automatic logic [31:0] link_to_word(input link_cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[EXT_SEL_BIT] = c.external_rollover_select;
        w[MASTER_BIT] = c.cycle_start_generator_enable;
        w[COUNT_BIT] = c.cycle_counting_enable;
        w[PHY_BIT] = c.phy_packet_accept;
        w[SELF_ID_BIT] = c.self_id_accept;
        return w;
    endfunction

    // Picks the link control bits out of a written word.
    function automatic link_cfg_s word_to_link(input logic [31:0] w);
        link_cfg_s c;
        c.external_rollover_select = w[EXT_SEL_BIT];
        c.cycle_start_generator_enable = w[MASTER_BIT];
        c.cycle_counting_enable = w[COUNT_BIT];
        c.phy_packet_accept = w[PHY_BIT];
        c.self_id_accept = w[SELF_ID_BIT];
        return c;
    endfunction

endpackage

/* File: design/cycle_offset_timer.sv */
// Cycle timer offset counter with internal or external rollover.
// Assumes tick and external_edge are one-cycle pulses on hclk.
`timescale 1ns/10ps
module cycle_offset_timer (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Configuration and timing strobes.
    input wire logic enable,
    input wire logic external_select,
    input wire logic external_edge,
    input wire logic tick,
    // Timer state.
    output logic [11:0] offset,
    output logic rollover
);

    logic [11:0] next_offset; // Offset after this edge.
    logic next_rollover; // Rollover pulse after this edge.

    // The offset freezes while counting is off, so software sees it hold.
    always_comb
    begin
        next_offset = offset;
        next_rollover = 1'b0;
        if (enable)
        begin
            if (external_select)
            begin
                if (external_edge)
                begin
                    next_offset = 12'h000;
                    next_rollover = 1'b1;
                end
                else if (tick && offset != 12'hfff)
                begin
                    // Saturates so a lost external edge cannot wrap silently.
                    next_offset = offset + 12'h001;
                end
            end
            else if (tick)
            begin
                if (offset == link_regs_pkg::ROLLOVER_TICKS - 12'h001)
                begin
                    next_offset = 12'h000;
                    next_rollover = 1'b1;
                end
                else
                begin
                    next_offset = offset + 12'h001;
                end
            end
        end
    end

    // Registers the timer state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            offset <= 12'h000;
            rollover <= 1'b0;
        end
        else
        begin
            offset <= next_offset;
            rollover <= next_rollover;
        end
    end

    a_offset_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
        !enable |=> $stable(offset))
        else $error("offset moved while counting was off");

    a_internal_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (enable && !external_select && tick && offset == 12'hbff)
        |=> (offset == 12'h000 && rollover))
        else $error("internal rollover not at 3072 ticks");

endmodule

/* File: design/priority_request_limiter.sv */
// Counts priority arbitration requests per fairness interval.
// Assumes want and interval_start come from logic on hclk.
`timescale 1ns/10ps
module priority_request_limiter (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Request side.
    input wire logic want,
    input wire logic interval_start,
    input wire logic [7:0] limit,
    // Grant and limit pulse.
    output logic grant,
    output logic limit_hit
);

    logic [7:0] count; // Grants made in the current interval.
    logic [7:0] next_count;
    logic next_limit_hit;

    // A limit of zero grants nothing, which is the reset behaviour.
    assign grant = want && !interval_start && (count < limit);

    // Counts grants and restarts at each interval boundary.
    always_comb
    begin
        next_count = count;
        next_limit_hit = 1'b0;
        if (interval_start)
        begin
            next_count = 8'h00;
        end
        else if (grant)
        begin
            next_count = count + 8'h01;
            next_limit_hit = (count + 8'h01 == limit);
        end
    end

    // Registers the counter.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 8'h00;
            limit_hit <= 1'b0;
        end
        else
        begin
            count <= next_count;
            limit_hit <= next_limit_hit;
        end
    end

    // Once the limit is reached the count must also stop moving, so a
    // stray increment path cannot hide behind a correct grant gate.
    a_grant_capped: assert property (@(posedge hclk) disable iff (!hresetn)
        (count >= limit && !interval_start)
        |-> !grant ##1 count == $past(count))
        else $error("priority request granted over the limit");

endmodule

/* File: design/iso_rx_mask_fairness_link_ctrl.sv */
// Register slice: receive interrupt mask, fairness limit, link control.
// Assumes an AHB-Lite master with single word transfers on hclk.
//
// Summary of operation
// - Receive summary interrupt gated per context mask.
// - Set and clear offsets both read mask.
// - Mask bits align with events; low four.
// - Limit priority requests per fairness interval.
// - Fairness upper 24 bits read zero.
// - Fairness register at own offset, resets zero.
// - Link control via set and clear offsets.
// - Only five link bits writable; others zero.
// - Rollover external or after 3072 ticks.
// - Overlong cycle clears master, blocks setting.
// - Counting enable stops or runs offset.
// - PHY accept gated by context; self-ID separate.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module iso_rx_mask_fairness_link_ctrl (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Receive context events and gated summary.
    input wire logic [3:0] iso_rx_event,
    output logic [3:0] iso_rx_mask,
    output logic iso_receive_summary_interrupt,
    // Priority arbitration request limiting.
    input wire logic pri_req_want,
    input wire logic fairness_interval_start,
    output logic pri_req_grant,
    // Cycle timer.
    input wire logic cycle_tick,
    input wire logic external_cycle_input,
    input wire logic overlong_cycle_event,
    output logic [11:0] cycle_offset,
    output logic cycle_rollover,
    output logic cycle_start_request,
    // Receiver controls.
    input wire logic ar_request_context_enabled,
    output logic phy_packet_admit,
    output logic self_id_accept,
    output link_regs_pkg::link_cfg_s link_config,
    // Block interrupt.
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave.

    link_regs_pkg::bus_state_e state; // Where the current transfer stands.
    link_regs_pkg::bus_state_e next_state;
    link_regs_pkg::bus_req_s req; // Address phase held for the data phase.
    link_regs_pkg::bus_req_s next_req;
    logic accept; // An address phase is taken at this edge.
    logic wr; // Data phase of a write is in this cycle.

    assign accept = hsel && htrans[1] && hready;
    assign wr = (state == link_regs_pkg::st_write);
    // Reads take one wait state so the read mux is always registered.
    assign hreadyout = (state != link_regs_pkg::st_read);
    // Every access, mapped or not, completes OKAY.
    assign hresp = 1'b0;

    // Steps the slave through address and data phases.
    always_comb
    begin
        next_req = accept ? {haddr[11:0], hwrite} : req;
        case (state)
            link_regs_pkg::st_read:
            begin
                // Hready is low here, so no new transfer can start.
                next_state = link_regs_pkg::st_read_out;
            end
            link_regs_pkg::st_idle,
            link_regs_pkg::st_write,
            link_regs_pkg::st_read_out:
            begin
                if (accept)
                begin
                    next_state = hwrite ? link_regs_pkg::st_write
                                        : link_regs_pkg::st_read;
                end
                else
                begin
                    next_state = link_regs_pkg::st_idle;
                end
            end
            default:
            begin
                next_state = link_regs_pkg::st_idle;
            end
        endcase
    end

    // Registers the slave state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= link_regs_pkg::st_idle;
            req <= '0;
        end
        else
        begin
            state <= next_state;
            req <= next_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [3:0] mask; // Per-context enables of the receive summary.
    logic [3:0] next_mask;
    logic [7:0] fair_limit; // Priority requests allowed per interval.
    logic [7:0] next_fair_limit;
    link_regs_pkg::link_cfg_s link; // Link control bits.
    link_regs_pkg::link_cfg_s next_link;
    link_regs_pkg::link_cfg_s wr_bits; // Written word as link fields.
    logic [2:0] status; // Sticky interrupt events.
    logic [2:0] next_status;
    logic [2:0] int_enable; // Interrupt enables, same layout as status.
    logic [2:0] next_int_enable;
    logic [2:0] events; // Events raised this cycle.
    logic [2:0] clear_bits; // Status bits software clears this cycle.
    logic [31:0] rd_word; // Read mux output.
    logic [31:0] next_hrdata;
    logic master_drop; // Master enable forced off this cycle.
    logic limit_hit; // Fairness limit just reached.

    assign wr_bits = link_regs_pkg::word_to_link(hwdata);
    assign master_drop = link.cycle_start_generator_enable
                         && overlong_cycle_event;
    assign events[link_regs_pkg::INT_ROLLOVER] = cycle_rollover;
    assign events[link_regs_pkg::INT_MASTER_DROP] = master_drop;
    assign events[link_regs_pkg::INT_FAIR_FULL] = limit_hit;
    assign clear_bits = (wr && req.addr == link_regs_pkg::OFS_INT_CLEAR)
                        ? hwdata[2:0] : 3'h0;

    // Computes register updates from writes and hardware events.
    always_comb
    begin
        next_mask = mask;
        next_fair_limit = fair_limit;
        next_link = link;
        next_int_enable = int_enable;
        if (wr)
        begin
            case (req.addr)
                link_regs_pkg::OFS_MASK_SET:
                begin
                    next_mask = mask | hwdata[3:0];
                end
                link_regs_pkg::OFS_MASK_CLEAR:
                begin
                    next_mask = mask & ~hwdata[3:0];
                end
                link_regs_pkg::OFS_FAIRNESS:
                begin
                    // Upper bits are dropped, they do not exist.
                    next_fair_limit = hwdata[7:0];
                end
                link_regs_pkg::OFS_LINK_SET:
                begin
                    next_link = link | wr_bits;
                end
                link_regs_pkg::OFS_LINK_CLEAR:
                begin
                    next_link = link & ~wr_bits;
                end
                link_regs_pkg::OFS_INT_ENABLE:
                begin
                    next_int_enable = hwdata[2:0];
                end
                default:
                begin
                    // Unmapped writes and the status port change nothing.
                    next_mask = mask;
                end
            endcase
        end
        // Hardware wins over software while the overlong event stands.
        if (overlong_cycle_event)
        begin
            next_link.cycle_start_generator_enable = 1'b0;
        end
        // A new event beats a clear arriving in the same cycle.
        next_status = (status & ~clear_bits) | events;
    end

    // Selects the read data for the addressed register.
    always_comb
    begin
        case (req.addr)
            link_regs_pkg::OFS_MASK_SET,
            link_regs_pkg::OFS_MASK_CLEAR:
            begin
                rd_word = {28'h0000000, mask};
            end
            link_regs_pkg::OFS_FAIRNESS:
            begin
                rd_word = {24'h000000, fair_limit};
            end
            link_regs_pkg::OFS_LINK_SET,
            link_regs_pkg::OFS_LINK_CLEAR:
            begin
                rd_word = link_regs_pkg::link_to_word(link);
            end
            link_regs_pkg::OFS_INT_STATUS:
            begin
                rd_word = {29'h00000000, status};
            end
            link_regs_pkg::OFS_INT_ENABLE:
            begin
                rd_word = {29'h00000000, int_enable};
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
        next_hrdata = (state == link_regs_pkg::st_read) ? rd_word : hrdata;
    end

    // Registers the register file.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mask <= link_regs_pkg::MASK_RESET;
            fair_limit <= link_regs_pkg::FAIRNESS_RESET;
            link <= link_regs_pkg::LINK_RESET;
            status <= link_regs_pkg::INT_RESET;
            int_enable <= link_regs_pkg::INT_RESET;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            mask <= next_mask;
            fair_limit <= next_fair_limit;
            link <= next_link;
            status <= next_status;
            int_enable <= next_int_enable;
            hrdata <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and datapath hooks.

    logic ext_meta; // First stage of the external cycle synchroniser.
    logic ext_sync; // Second stage, safe to read.
    logic ext_prev; // Previous synchronised level.
    logic ext_edge; // Rising edge of the external cycle input.
    logic next_summary;
    logic next_irq;

    assign ext_edge = ext_sync && !ext_prev;
    assign next_summary = |(iso_rx_event & mask);
    assign next_irq = |(next_status & next_int_enable);
    assign iso_rx_mask = mask;
    assign link_config = link;
    assign self_id_accept = link.self_id_accept;
    assign cycle_start_request = cycle_rollover
                                 && link.cycle_start_generator_enable;

    // Synchronises the pin and registers the interrupt outputs.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            iso_receive_summary_interrupt <= 1'b0;
            phy_packet_admit <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ext_meta <= external_cycle_input;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            iso_receive_summary_interrupt <= next_summary;
            phy_packet_admit <= link.phy_packet_accept
                                && ar_request_context_enabled;
            irq <= next_irq;
        end
    end

    // Cycle timer offset.
    cycle_offset_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(link.cycle_counting_enable),
        .external_select(link.external_rollover_select),
        .external_edge(ext_edge),
        .tick(cycle_tick),
        .offset(cycle_offset),
        .rollover(cycle_rollover)
    );

    // Priority request limiter.
    priority_request_limiter u_limiter (
        .hclk(hclk),
        .hresetn(hresetn),
        .want(pri_req_want),
        .interval_start(fairness_interval_start),
        .limit(fair_limit),
        .grant(pri_req_grant),
        .limit_hit(limit_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence read_taken(logic [11:0] a);
        accept && !hwrite && haddr[11:0] == a;
    endsequence

    sequence read_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite) |=> read_answer)
        else $error("read answer not after one wait state");

    a_mask_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        read_taken(link_regs_pkg::OFS_MASK_CLEAR)
        |=> ##1 hrdata == {28'h0000000, $past(mask)})
        else $error("mask clear offset read wrong");

    a_fair_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        read_taken(link_regs_pkg::OFS_FAIRNESS)
        |=> ##1 hrdata[31:8] == 24'h000000)
        else $error("fairness upper bits not zero");

    a_mask_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && req.addr == link_regs_pkg::OFS_MASK_SET)
        |=> mask == ($past(mask) | $past(hwdata[3:0])))
        else $error("mask set write wrong");

    a_link_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && req.addr == link_regs_pkg::OFS_LINK_CLEAR && hwdata[20])
        |=> !link.cycle_counting_enable)
        else $error("link clear did not clear counting enable");

    a_master_block: assert property (@(posedge hclk) disable iff (!hresetn)
        overlong_cycle_event |=> !link.cycle_start_generator_enable)
        else $error("master enable survived overlong cycle");

    a_summary_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 iso_receive_summary_interrupt
        == |($past(iso_rx_event) & $past(mask)))
        else $error("summary interrupt not gated by mask");

    a_status_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        cycle_rollover |=> status[link_regs_pkg::INT_ROLLOVER])
        else $error("rollover event lost");

endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the register slice over its AHB-Lite port.
// Assumes one clock, hready looped from hreadyout, word transfers only.
`timescale 1ns/10ps
module tb_top;
    // Bus and side-band stimulus, all driven after rising edges.
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, iso_receive_summary_interrupt, pri_req_grant;
    logic [31:0] hrdata;
    logic [3:0] iso_rx_event = 0, iso_rx_mask;
    logic pri_req_want = 0, fairness_interval_start = 0, cycle_tick = 0;
    logic external_cycle_input = 0, overlong_cycle_event = 0, irq;
    logic ar_request_context_enabled = 0, phy_packet_admit, self_id_accept;
    logic [11:0] cycle_offset;
    logic cycle_rollover, cycle_start_request;
    link_regs_pkg::link_cfg_s link_config;
    int bad_count = 0, checks = 0, grants = 0, rolls = 0, starts = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    iso_rx_mask_fairness_link_ctrl iso_rx_mask_fairness_link_ctrl_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .iso_rx_event, .iso_rx_mask,
        .iso_receive_summary_interrupt, .pri_req_want,
        .fairness_interval_start, .pri_req_grant, .cycle_tick,
        .external_cycle_input, .overlong_cycle_event, .cycle_offset,
        .cycle_rollover, .cycle_start_request, .ar_request_context_enabled,
        .phy_packet_admit, .self_id_accept, .link_config, .irq);
    ////////////////////////////////////////////////////////////////////////
    // Grants and rollover pulses are counted as the design samples them.
    always @(posedge hclk)
    begin
        if (pri_req_grant === 1'b1) grants++;
        if (cycle_rollover === 1'b1) rolls++;
        if (cycle_start_request === 1'b1) starts++;
    end
    // Compares a word and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single write: address phase held until hready, then data phase.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'b10; hwrite <= 1; haddr <= {20'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask
    // Single read; data is taken at the edge that ends the data phase.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'b10; hwrite <= 0; haddr <= {20'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 0; htrans <= 2'b00;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        chk(hrdata, exp);
    endtask
    // One-cycle timer ticks spaced a cycle apart, as the timer expects.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge hclk) cycle_tick <= 1;
            @(posedge hclk) cycle_tick <= 0;
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // The timer test dominates at about 6200 cycles; allow three times.
    initial
    begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        tally_and_finish;
    end
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        rd(12'h0dc, 32'h0);
        rd(12'h0f0, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        // Upper mask bits must not stick; clear removes only ones.
        wr(12'h0a8, 32'hffff_ffff);
        rd(12'h0ac, 32'h0000_000f);
        wr(12'h0ac, 32'h0000_0005);
        rd(12'h0a8, 32'h0000_000a);
        chk({28'h0, iso_rx_mask}, 32'ha);
        iso_rx_event <= 4'h5;
        repeat (3) @(posedge hclk);
        chk({31'h0, iso_receive_summary_interrupt}, 32'h0);
        iso_rx_event <= 4'h2;
        repeat (3) @(posedge hclk);
        chk({31'h0, iso_receive_summary_interrupt}, 32'h1);
        // Link control keeps only its five bits.
        wr(12'h0e0, 32'hffff_ffff);
        rd(12'h0e4, 32'h0070_0600);
        wr(12'h0e4, 32'h0040_0000);
        rd(12'h0e0, 32'h0030_0600);
        chk({27'h0, link_config}, 32'h0000_000f);
        ar_request_context_enabled <= 1;
        repeat (3) @(posedge hclk);
        chk({30'h0, phy_packet_admit, self_id_accept}, 32'h3);
        // Internal rollover after exactly 3072 ticks raises the irq.
        wr(12'h108, 32'h1);
        tick(3071);
        repeat (3) @(posedge hclk);
        chk({20'h0, cycle_offset}, 32'hbff);
        chk(32'(rolls), 32'h0);
        tick(1);
        repeat (3) @(posedge hclk);
        chk({20'h0, cycle_offset}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        chk(32'(rolls), 32'h1);
        chk(32'(starts), 32'h1);
        rd(12'h100, 32'h1);
        wr(12'h104, 32'h1);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        // Counting disabled freezes the offset.
        wr(12'h0e4, 32'h0010_0000);
        tick(5);
        repeat (3) @(posedge hclk);
        chk({20'h0, cycle_offset}, 32'h0);
        // External rollover follows the synchronised pin edge.
        wr(12'h0e0, 32'h0050_0000);
        tick(5);
        repeat (3) @(posedge hclk);
        chk({20'h0, cycle_offset}, 32'h5);
        external_cycle_input <= 1;
        repeat (6) @(posedge hclk);
        chk({20'h0, cycle_offset}, 32'h0);
        chk(32'(rolls), 32'h2);
        chk(32'(starts), 32'h2);
        external_cycle_input <= 0;
        // Priority request limit of two in one interval.
        wr(12'h0dc, 32'hffff_ffff);
        rd(12'h0dc, 32'h0000_00ff);
        wr(12'h0dc, 32'h2);
        @(posedge hclk) fairness_interval_start <= 1;
        @(posedge hclk) fairness_interval_start <= 0;
        grants = 0;
        pri_req_want <= 1;
        repeat (10) @(posedge hclk);
        pri_req_want <= 0;
        @(posedge hclk);
        chk(32'(grants), 32'h2);
        rd(12'h100, 32'h5);
        // Overlong cycle drops the master bit and blocks setting it.
        wr(12'h0e4, 32'hffff_ffff);
        wr(12'h0e0, 32'h0020_0000);
        overlong_cycle_event <= 1;
        repeat (3) @(posedge hclk);
        rd(12'h0e0, 32'h0);
        wr(12'h0e0, 32'h0020_0000);
        rd(12'h0e0, 32'h0);
        overlong_cycle_event <= 0;
        wr(12'h0e0, 32'h0020_0000);
        rd(12'h0e0, 32'h0020_0000);
        rd(12'h100, 32'h7);
        tally_and_finish;
    end
endmodule
